// ==== hw/vector_address_map.sv ====
/*
 Reset and interrupt vector address generator for an 8-bit core.
 Assumes the core acknowledges each dispatched vector and that
 requests are level, held by their sources until serviced.
*/
// Notes on behaviour
// - After any reset, execution is sent to the reset vector, at 0x000 while the boot fuse is unprogrammed.
// - External requests 0 and 1 use table offsets 0x001 and 0x002.
// - Pin-change requests 0, 1, 2 use offsets 0x003 to 0x005.
// - Watchdog time-out interrupt uses offset 0x006.
// - Second 8-bit timer compare A, compare B, overflow use 0x007 to 0x009.
// - 16-bit timer capture, compare A, compare B, overflow use 0x00A to 0x00D.
// - First 8-bit timer compare A, compare B, overflow use 0x00E to 0x010.
// - Serial transfer complete uses offset 0x011.
// - USART receive, buffer empty, transmit complete use 0x012 to 0x014.
// - ADC, EEPROM, comparator, two-wire, program store use 0x015 to 0x019.
// - Programmed boot fuse sends reset to the boot reset address.
// - Table select set adds boot section start to every interrupt vector address.
// - Fuse picks reset target, select bit picks table base, independently.
// - Fuse value 1 means unprogrammed, 0 means programmed.
`timescale 1ns/100ps
`default_nettype none
`include "vector_map_consts.svh"
module vector_address_map
	import vector_map_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RSTN,
	// Configuration
	input wire logic BOOT_RESET_SELECT_FUSE,
	input wire logic VECTOR_TABLE_SELECT,
	input wire logic [`VEC_ADDR_W-1:0] BOOT_RESET_ADDR,
	// Interrupt sources
	input wire logic EXTERNAL_REQUEST_0,
	input wire logic EXTERNAL_REQUEST_1,
	input wire logic PIN_CHANGE_REQUEST_0,
	input wire logic PIN_CHANGE_REQUEST_1,
	input wire logic PIN_CHANGE_REQUEST_2,
	input wire logic WATCHDOG_TIMEOUT,
	input wire logic TMR2_COMPARE_MATCH_A,
	input wire logic TMR2_COMPARE_MATCH_B,
	input wire logic TMR2_OVERFLOW,
	input wire logic TMR1_CAPTURE_EVENT,
	input wire logic TMR1_COMPARE_MATCH_A,
	input wire logic TMR1_COMPARE_MATCH_B,
	input wire logic TMR1_OVERFLOW,
	input wire logic TMR0_COMPARE_MATCH_A,
	input wire logic TMR0_COMPARE_MATCH_B,
	input wire logic TMR0_OVERFLOW,
	input wire logic SERIAL_TRANSFER_COMPLETE,
	input wire logic USART_RECEIVE_COMPLETE,
	input wire logic TRANSMIT_BUFFER_EMPTY,
	input wire logic USART_TRANSMIT_COMPLETE,
	input wire logic ADC_COMPLETE,
	input wire logic EEPROM_READY,
	input wire logic ANALOG_COMPARATOR,
	input wire logic TWO_WIRE_INTERFACE,
	input wire logic PROGRAM_STORE_READY,
	// Global enable from the core
	input wire logic GLOBAL_ENABLE,
	// Vector fetch handshake with the core
	output logic VEC_VALID,
	output logic [`VEC_ADDR_W-1:0] VEC_ADDR,
	output logic [`VEC_NUM_W-1:0] VEC_NUM,
	output logic VEC_IS_RESET,
	input wire logic VEC_ACK
);
	// ----------------------------------------------------------------
	// Request vector, bit k is vector number k+2
	// ----------------------------------------------------------------
	logic [`VEC_SRC_N-1:0] req;
	logic any;
	vec_idx_t idx;
	vec_addr_t reset_tgt;
	vec_addr_t table_base;
	vec_state_t state_q;
	vec_state_t state_d;
	vec_addr_t addr_q;
	vec_idx_t num_q;
	logic is_reset_q;

	// Order of the concatenation fixes the table layout
	assign req = {
		PROGRAM_STORE_READY, TWO_WIRE_INTERFACE, ANALOG_COMPARATOR,
		EEPROM_READY, ADC_COMPLETE,
		USART_TRANSMIT_COMPLETE, TRANSMIT_BUFFER_EMPTY,
		USART_RECEIVE_COMPLETE,
		SERIAL_TRANSFER_COMPLETE,
		TMR0_OVERFLOW, TMR0_COMPARE_MATCH_B, TMR0_COMPARE_MATCH_A,
		TMR1_OVERFLOW, TMR1_COMPARE_MATCH_B, TMR1_COMPARE_MATCH_A,
		TMR1_CAPTURE_EVENT,
		TMR2_OVERFLOW, TMR2_COMPARE_MATCH_B, TMR2_COMPARE_MATCH_A,
		WATCHDOG_TIMEOUT,
		PIN_CHANGE_REQUEST_2, PIN_CHANGE_REQUEST_1, PIN_CHANGE_REQUEST_0,
		EXTERNAL_REQUEST_1, EXTERNAL_REQUEST_0
	} & {`VEC_SRC_N{GLOBAL_ENABLE}};

	// ----------------------------------------------------------------
	// Submodules
	// ----------------------------------------------------------------
	vec_priority u_prio (
		.req(req),
		.any(any),
		.idx(idx)
	);

	vec_base_sel u_base (
		.fuse(BOOT_RESET_SELECT_FUSE),
		.tbl_sel(VECTOR_TABLE_SELECT),
		.boot_addr(BOOT_RESET_ADDR),
		.reset_tgt(reset_tgt),
		.table_base(table_base)
	);

	// ----------------------------------------------------------------
	// Dispatch state machine
	// ----------------------------------------------------------------
	// Reset vector is always offered first, before any interrupt
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_RESET: state_d = ST_ACK;
			ST_IDLE: begin
				if (any) begin
					state_d = ST_ACK;
				end
			end
			ST_ACK: begin
				if (VEC_ACK) begin
					state_d = ST_IDLE;
				end
			end
			default: state_d = ST_RESET;
		endcase
	end

	// State register
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			state_q <= ST_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	// Address capture; held stable while waiting for the core
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			addr_q <= `VEC_RESET_ADDR;
			num_q <= `VEC_RESET_NUM;
			is_reset_q <= 1'b0;
		end else if (state_q == ST_RESET) begin
			addr_q <= reset_tgt;
			num_q <= `VEC_RESET_NUM;
			is_reset_q <= 1'b1;
		end else if (state_q == ST_IDLE && any) begin
			// Vector number idx+2, so base plus number minus one is base+idx+1
			addr_q <= table_base + {7'h00, idx};
			num_q <= idx + `VEC_FIRST_IRQ_NUM;
			is_reset_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign VEC_VALID = (state_q == ST_ACK);
	assign VEC_ADDR = addr_q;
	assign VEC_NUM = num_q;
	assign VEC_IS_RESET = is_reset_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Reset offer, an idle pick, and the interrupt offer it leads to
	sequence s_reset_offer;
		VEC_VALID && VEC_IS_RESET;
	endsequence

	sequence s_irq_pick;
		state_q == ST_IDLE && any;
	endsequence

	sequence s_irq_offer;
		VEC_VALID && !VEC_IS_RESET;
	endsequence

	// ----------------------------------------------------------------
	// Reset offer checks
	// ----------------------------------------------------------------
	// No disable here, since the release edge itself is what is watched
	reset_first_a: assert property (@(posedge CLK) $rose(RSTN) |-> ##1 s_reset_offer)
		else $error("reset vector not offered after reset");

	// Nothing is offered while reset is held
	reset_quiet_a: assert property (@(posedge CLK) !RSTN |-> !VEC_VALID)
		else $error("offer made during reset");

	// Every reset offer carries vector number one
	reset_num_a: assert property (@(posedge CLK) disable iff (!RSTN)
		s_reset_offer |-> VEC_NUM == `VEC_RESET_NUM)
		else $error("reset offer has wrong vector number");

	// An untaken reset offer must not be replaced by an interrupt
	reset_hold_a: assert property (@(posedge CLK) disable iff (!RSTN)
		(VEC_VALID && VEC_IS_RESET && !VEC_ACK) |=> s_reset_offer)
		else $error("reset offer replaced before it was taken");

	// Reset target follows the fuse, whatever the select bit says
	reset_target_a: assert property (@(posedge CLK) disable iff (!RSTN)
		s_reset_offer |-> (VEC_ADDR == ((BOOT_RESET_SELECT_FUSE == 1'b0)
		? BOOT_RESET_ADDR : 12'h000)))
		else $error("wrong reset target");

	// Fuse value one is the unprogrammed state, reset goes to zero
	fuse_unprog_a: assert property (@(posedge CLK) disable iff (!RSTN)
		(VEC_VALID && VEC_IS_RESET && BOOT_RESET_SELECT_FUSE) |-> VEC_ADDR == 12'h000)
		else $error("unprogrammed fuse did not give address zero");

	// Fuse value zero is the programmed state, reset goes to the boot section
	fuse_prog_a: assert property (@(posedge CLK) disable iff (!RSTN)
		(VEC_VALID && VEC_IS_RESET && !BOOT_RESET_SELECT_FUSE)
		|-> VEC_ADDR == BOOT_RESET_ADDR)
		else $error("programmed fuse did not give the boot reset address");

	// ----------------------------------------------------------------
	// Table layout checks
	// ----------------------------------------------------------------
	// First table slot belongs to external request 0
	ext0_vec_a: assert property (@(posedge CLK) disable iff (!RSTN)
		(state_q == ST_IDLE && GLOBAL_ENABLE && EXTERNAL_REQUEST_0 && !VECTOR_TABLE_SELECT)
		|=> VEC_VALID && VEC_ADDR == 12'h001)
		else $error("external request 0 not at offset one");

	// Last table slot belongs to program store ready
	store_ready_vec_a: assert property (@(posedge CLK) disable iff (!RSTN)
		(state_q == ST_IDLE && req == 25'h1000000 && !VECTOR_TABLE_SELECT)
		|=> VEC_ADDR == 12'h019)
		else $error("program store ready not at 0x019");

	// A lone request lands on its own slot; one loop covers every source
	generate
		for (genvar k = 0; k < `VEC_SRC_N; k++) begin : g_slot
			slot_addr_a: assert property (
				@(posedge CLK) disable iff (!RSTN)
				(state_q == ST_IDLE && req == (25'h0000001 << k))
				|=> VEC_VALID && VEC_NUM == 5'(k + 2)
				&& VEC_ADDR == ($past(VECTOR_TABLE_SELECT) ? BOOT_RESET_ADDR : 12'h000)
				+ 12'(k + 1))
				else $error("lone request not at its own table slot");
		end
	endgenerate

	// Relocated table: boot section start added to the default address
	table_move_a: assert property (@(posedge CLK) disable iff (!RSTN)
		(state_q == ST_IDLE && any && VECTOR_TABLE_SELECT)
		|=> VEC_ADDR == BOOT_RESET_ADDR + {7'h00, $past(idx)} + 12'h001)
		else $error("relocated vector address wrong");

	// Address is the table base plus the number less one, in either place
	addr_form_a: assert property (@(posedge CLK) disable iff (!RSTN)
		s_irq_offer |-> VEC_ADDR == (VECTOR_TABLE_SELECT ?
		BOOT_RESET_ADDR : 12'h000) + {7'h00, VEC_NUM} - 12'h001)
		else $error("address is not base plus number minus one");

	// Default table stays inside its 25 slots above the reset word
	table_default_a: assert property (@(posedge CLK) disable iff (!RSTN)
		(VEC_VALID && !VEC_IS_RESET && !VECTOR_TABLE_SELECT)
		|-> (VEC_ADDR >= 12'h001 && VEC_ADDR <= 12'h019))
		else $error("default table address out of range");

	// Interrupt offers only carry vector numbers two to twenty-six
	num_range_a: assert property (@(posedge CLK) disable iff (!RSTN)
		s_irq_offer |-> (VEC_NUM >= 5'h02 && VEC_NUM <= 5'h1A))
		else $error("interrupt vector number out of range");

	// ----------------------------------------------------------------
	// Handshake and priority checks
	// ----------------------------------------------------------------
	// Lowest and highest pending together: the lowest goes first
	prio_low_a: assert property (@(posedge CLK) disable iff (!RSTN)
		(state_q == ST_IDLE && req[0] && req[24]) |=> VEC_NUM == 5'h02)
		else $error("lowest vector not dispatched first");

	// Every idle pick is offered on the next cycle
	pick_offer_a: assert property (@(posedge CLK) disable iff (!RSTN)
		s_irq_pick |=> s_irq_offer)
		else $error("picked request not offered");

	// With the global enable low nothing is offered from idle
	gate_off_a: assert property (@(posedge CLK) disable iff (!RSTN)
		(state_q == ST_IDLE && !GLOBAL_ENABLE) |=> !VEC_VALID)
		else $error("offer made while interrupts disabled");

	// Taking an offer ends it; a new pick needs an idle cycle first
	ack_drop_a: assert property (@(posedge CLK) disable iff (!RSTN)
		(VEC_VALID && VEC_ACK) |=> !VEC_VALID)
		else $error("offer still standing after it was taken");

	// Offer holds still until the core takes it
	hold_wait_a: assert property (@(posedge CLK) disable iff (!RSTN)
		(VEC_VALID && !VEC_ACK) |=> VEC_VALID && $stable(VEC_ADDR) && $stable(VEC_NUM))
		else $error("offered vector changed before acknowledge");
endmodule : vector_address_map
`default_nettype wire

// ==== shared/vector_map_consts.svh ====
/*
 Constants for the reset and interrupt vector address generator.
 Assumes inclusion by bare name from any design file.
*/
`ifndef VECTOR_MAP_CONSTS_SVH
`define VECTOR_MAP_CONSTS_SVH
// ----------------------------------------------------------------
// Address widths and counts
// ----------------------------------------------------------------
`define VEC_ADDR_W 12
`define VEC_SRC_N 25
`define VEC_NUM_W 5
// ----------------------------------------------------------------
// Addresses
// ----------------------------------------------------------------
`define VEC_RESET_ADDR 12'h000
`define VEC_TABLE_BASE 12'h001
`define VEC_BOOT_RESET_DEFAULT 12'hC00
// ----------------------------------------------------------------
// Vector numbers
// ----------------------------------------------------------------
`define VEC_RESET_NUM 5'h01
`define VEC_FIRST_IRQ_NUM 5'h02
// ----------------------------------------------------------------
// Fuse encoding
// ----------------------------------------------------------------
`define FUSE_PROGRAMMED 1'h0
`define FUSE_UNPROGRAMMED 1'h1
`endif

// ==== shared/vector_map_pkg.sv ====
/*
 Types for the vector address generator.
 Assumes vector_map_consts.svh is visible on the include path.
*/
`include "vector_map_consts.svh"
package vector_map_pkg;
	typedef logic [`VEC_ADDR_W-1:0] vec_addr_t;
	typedef logic [`VEC_SRC_N-1:0] vec_req_t;
	typedef logic [`VEC_NUM_W-1:0] vec_idx_t;
	typedef enum logic [1:0] {
		ST_RESET = 2'h0,
		ST_IDLE = 2'h1,
		ST_ACK = 2'h2
	} vec_state_t;
endpackage : vector_map_pkg

// ==== hw/vec_priority.sv ====
/*
 Fixed priority picker over the 25 interrupt request lines.
 Assumes requests are already gated by their enables.
*/
`timescale 1ns/100ps
`default_nettype none
`include "vector_map_consts.svh"
module vec_priority
	import vector_map_pkg::*;
(
	// Requests, bit 0 is the lowest vector
	input wire logic [`VEC_SRC_N-1:0] req,
	// Result
	output logic any,
	output logic [`VEC_NUM_W-1:0] idx
);
	// Lowest index wins; scan from the top so the last hit stays
	always_comb begin
		any = 1'b0;
		idx = '0;
		for (int i = `VEC_SRC_N-1; i >= 0; i--) begin
			if (req[i]) begin
				any = 1'b1;
				idx = i[`VEC_NUM_W-1:0];
			end
		end
	end
endmodule : vec_priority
`default_nettype wire

// ==== hw/vec_base_sel.sv ====
/*
 Selects reset target and interrupt table base from fuse and select bit.
 Assumes boot reset address is stable while the core runs.
*/
`timescale 1ns/100ps
`default_nettype none
`include "vector_map_consts.svh"
module vec_base_sel
	import vector_map_pkg::*;
(
	// Configuration
	input wire logic fuse,
	input wire logic tbl_sel,
	input wire logic [`VEC_ADDR_W-1:0] boot_addr,
	// Bases
	output logic [`VEC_ADDR_W-1:0] reset_tgt,
	output logic [`VEC_ADDR_W-1:0] table_base
);
	// Fuse drives only the reset target, select bit only the table
	always_comb begin
		reset_tgt = (fuse == `FUSE_PROGRAMMED) ? boot_addr : `VEC_RESET_ADDR;
		table_base = tbl_sel ? (boot_addr + `VEC_TABLE_BASE) : `VEC_TABLE_BASE;
	end
endmodule : vec_base_sel
`default_nettype wire

// ==== sim/core_model.sv ====
/*
 Core model that takes vector offers, promptly or after a stall.
 Assumes the generator's handshake on the same clock and reset.
*/
`timescale 1ns/100ps
`default_nettype none
`include "vector_map_consts.svh"
module core_model
	import vector_map_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Offer from the generator
	input wire logic valid,
	input wire logic [`VEC_ADDR_W-1:0] addr,
	input wire logic [`VEC_NUM_W-1:0] num,
	input wire logic is_rst,
	output logic ack,
	// Bench side
	input wire logic [1:0] dly,
	output logic got,
	output logic [`VEC_ADDR_W-1:0] got_addr,
	output logic [`VEC_NUM_W-1:0] got_num,
	output logic got_rst
);
	logic [1:0] wait_q;
	// Stall count never passes dly, so it cannot wrap
	assign ack = valid && (wait_q >= dly);
	// Capture each accepted vector as the fetch would
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wait_q <= 2'h0;
			got <= 1'b0;
			got_addr <= 12'h000;
			got_num <= 5'h00;
			got_rst <= 1'b0;
		end else begin
			got <= valid && ack;
			wait_q <= (valid && !ack) ? wait_q + 2'h1 : 2'h0;
			if (valid && ack) begin
				got_addr <= addr;
				got_num <= num;
				got_rst <= is_rst;
			end
		end
	end
endmodule : core_model
`default_nettype wire

// ==== sim/test_vector_address_map.sv ====
/*
 Self-checking bench for the vector address generator.
 Assumes the generator and core_model compiled before it.
*/
`timescale 1ns/100ps
`default_nettype none
`include "vector_map_consts.svh"
module test_vector_address_map
	import vector_map_pkg::*;
;
	// Reset starts released so that its first assertion is a real falling edge
	logic CLK = 0, RSTN = 1, fuse = 1, sel = 0, gen = 0;
	vec_addr_t boot = `VEC_BOOT_RESET_DEFAULT;
	vec_req_t req = '0;
	logic [1:0] dly = 2'h0;
	logic valid, is_rst, ack, got, got_rst;
	vec_addr_t addr, got_addr;
	vec_idx_t num, got_num;
	logic [31:0] lfsr = 32'h96AA;
	int err_total = 0;
	int samples_checked = 0;
	// ----------------------------------------
	// Clock, design and core
	// ----------------------------------------
	always #5 CLK = ~CLK;
	vector_address_map DUT (.CLK(CLK), .RSTN(RSTN), .BOOT_RESET_SELECT_FUSE(fuse),
		.VECTOR_TABLE_SELECT(sel), .BOOT_RESET_ADDR(boot), .GLOBAL_ENABLE(gen),
		.EXTERNAL_REQUEST_0(req[0]), .EXTERNAL_REQUEST_1(req[1]),
		.PIN_CHANGE_REQUEST_0(req[2]), .PIN_CHANGE_REQUEST_1(req[3]),
		.PIN_CHANGE_REQUEST_2(req[4]), .WATCHDOG_TIMEOUT(req[5]),
		.TMR2_COMPARE_MATCH_A(req[6]), .TMR2_COMPARE_MATCH_B(req[7]), .TMR2_OVERFLOW(req[8]),
		.TMR1_CAPTURE_EVENT(req[9]), .TMR1_COMPARE_MATCH_A(req[10]),
		.TMR1_COMPARE_MATCH_B(req[11]), .TMR1_OVERFLOW(req[12]),
		.TMR0_COMPARE_MATCH_A(req[13]), .TMR0_COMPARE_MATCH_B(req[14]),
		.TMR0_OVERFLOW(req[15]), .SERIAL_TRANSFER_COMPLETE(req[16]),
		.USART_RECEIVE_COMPLETE(req[17]), .TRANSMIT_BUFFER_EMPTY(req[18]),
		.USART_TRANSMIT_COMPLETE(req[19]), .ADC_COMPLETE(req[20]), .EEPROM_READY(req[21]),
		.ANALOG_COMPARATOR(req[22]), .TWO_WIRE_INTERFACE(req[23]),
		.PROGRAM_STORE_READY(req[24]), .VEC_VALID(valid), .VEC_ADDR(addr), .VEC_NUM(num),
		.VEC_IS_RESET(is_rst), .VEC_ACK(ack));
	core_model CORE (.clk(CLK), .rstn(RSTN), .valid(valid), .addr(addr), .num(num),
		.is_rst(is_rst), .ack(ack), .dly(dly), .got(got), .got_addr(got_addr),
		.got_num(got_num), .got_rst(got_rst));
	// ----------------------------------------
	// Expectations and helpers
	// ----------------------------------------
	function automatic logic [31:0] next_rand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : next_rand
	// Lowest set request wins; bit 0 is vector 2
	function automatic vec_idx_t exp_num(input vec_req_t r);
		for (int i = 0; i < `VEC_SRC_N; i++) begin
			if (r[i]) return vec_idx_t'(i + 2);
		end
		return 5'h00;
	endfunction : exp_num
	function automatic vec_addr_t exp_addr(input vec_req_t r, input logic s, input vec_addr_t b);
		return (s ? b : 12'h000) + 12'h001 + vec_addr_t'(exp_num(r)) - 12'h002;
	endfunction : exp_addr
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : stop_test
	// Bounded wait for the core to take an offer
	task automatic take();
		int n;
		n = 0;
		do begin
			@(posedge CLK);
			#1;
			n++;
		end while (got !== 1'b1 && n < 60);
		if (got !== 1'b1) begin
			check("handshake taken", got, 1'b1);
			stop_test();
		end
	endtask : take
	task automatic do_reset();
		RSTN = 0;
		repeat (10) @(posedge CLK);
		#1 RSTN = 1;
		take();
		check("reset addr", got_addr, fuse ? 12'h000 : boot);
		check("reset num", got_num, 5'h01);
		check("reset flag", got_rst, 1'b1);
	endtask : do_reset
	// Sources hold until served, then drop; stall varies at random
	task automatic serve();
		vec_addr_t ea;
		vec_idx_t en;
		while (req != '0) begin
			lfsr = next_rand(lfsr);
			dly = lfsr[1:0];
			ea = exp_addr(req, sel, boot);
			en = exp_num(req);
			take();
			check("vec addr", got_addr, ea);
			check("vec num", got_num, en);
			check("vec flag", got_rst, 1'b0);
			req[en - 5'h02] = 1'b0;
		end
	endtask : serve
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		#1;
		for (int c = 0; c < 4; c++) begin
			lfsr = next_rand(lfsr);
			fuse = c[1];
			sel = c[0];
			boot = {lfsr[11:5], 5'h00};
			req = lfsr[31:7];
			gen = 1;
			do_reset();
			serve();
			$display("reset combination %0d done", c);
		end
		for (int i = 0; i < `VEC_SRC_N; i++) begin
			sel = i[0];
			req = vec_req_t'(1) << i;
			serve();
		end
		$display("single sources done");
		repeat (40) begin
			lfsr = next_rand(lfsr);
			sel = lfsr[3];
			req = lfsr[30:6];
			serve();
		end
		$display("random bursts done");
		gen = 0;
		req = 25'h1000001;
		repeat (6) begin
			@(posedge CLK);
			#1;
			check("gated valid", valid, 1'b0);
		end
		gen = 1;
		serve();
		$display("enable gating done");
		stop_test();
	end
endmodule : test_vector_address_map
`default_nettype wire
